// *** logic/ast_params.svh ***
/*
 Register map, field and reset constants for the asynchronous serial transmitter.
 Assumes inclusion by the package, the transmitter module and the testbench.
*/
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH

// Register offsets on the plain register port (byte lanes unused)
`define AST_ADDR_WIDTH      4
`define AST_OFF_BUFFER      4'h0
`define AST_OFF_TX_CTRL     4'h1
`define AST_OFF_RX_CTRL     4'h2
`define AST_OFF_BAUD_CTRL   4'h3
`define AST_OFF_DIV_LOW     4'h4
`define AST_OFF_DIV_HIGH    4'h5
`define AST_OFF_FLAGS       4'h6
`define AST_OFF_IRQ_EN      4'h7

// Field positions, transmit status/control
`define AST_TXC_NINTH_DATA  0
`define AST_TXC_SHIFT_IDLE  1
`define AST_TXC_SYNC        4
`define AST_TXC_ENABLE      5
`define AST_TXC_NINE_BITS   6
// Receive control: port enable
`define AST_RXC_PORT_EN     7
// Baud control
`define AST_BDC_WIDE_DIV    3
`define AST_BDC_POLARITY    4
// Flag register and enable register
`define AST_FLG_BUF_EMPTY   0
`define AST_IEN_BUF_EMPTY   0

// Reset values
`define AST_RST_TX_CTRL     8'h02
`define AST_RST_BYTE        8'h00
`define AST_RST_DIVIDER     16'h0000

`endif

// *** logic/ast_pkg.sv ***
/*
 Types for the asynchronous serial transmitter.
 Assumes ast_params.svh is on the include path.
*/
`include "ast_params.svh"

package ast_pkg;

   // Serializer sequencer, one-hot
   typedef enum logic [3:0] {
      AST_IDLE  = 4'b0001,
      AST_START = 4'b0010,
      AST_DATA  = 4'b0100,
      AST_STOP  = 4'b1000
   } ast_state_type;

   typedef logic [`AST_ADDR_WIDTH-1:0] ast_addr_type;

endpackage : ast_pkg

// *** logic/ast_transmitter.sv ***
/*
 Asynchronous serial transmitter with its register port, baud divider,
 transmit buffer and hidden shift register.
 Assumes a single 100 MHz clock, a synchronous active-high reset and a
 register master that never strobes read and write in the same cycle.
*/
// Contract
// - Idle line rests at mark; data bits are NRZ held for whole bit.
// - Frame is one start, eight or nine data bits, one stop.
// - Start bit is space, stop bit is mark.
// - Every bit lasts exactly one bit period.
// - Bit period from a divider working as 8-bit or 16-bit.
// - Data bits go out least significant bit first.
// - Transmitter independent of receiver, sharing format and divider.
// - No parity hardware; software places parity in the ninth bit.
// - Hidden shift register loads only from the transmit buffer.
// - Port enable makes the transmit pin an output.
// - Setting transmit enable sets the buffer empty flag.
// - Buffer write starts send; idle shifter loads at once.
// - Queued character loads within one cycle after stop bit.
// - Polarity bit zero is high-true; one inverts idle and data.
// - Polarity inversion acts only in asynchronous mode.
// - Empty flag set when enabled and buffer holds nothing.
// - Empty flag valid on the second cycle after a write.
// - Empty flag read-only, changed only by hardware.
// - Interrupt enable gates only the request, never the flag.
`timescale 1ns/100ps
`default_nettype none
`include "ast_params.svh"

module ast_transmitter
   import ast_pkg::*;
(
   input  wire logic       clock,        // 100 MHz system clock
   input  wire logic       rst,          // Synchronous reset, active high
   input  wire logic [3:0] reg_addr,     // Register address
   input  wire logic [7:0] reg_wdata,    // Register write data
   input  wire logic       reg_write,    // Write strobe
   input  wire logic       reg_read,     // Read strobe
   output logic      [7:0] reg_rdata,    // Read data, cycle after strobe
   output logic            tx_pin_out,   // Transmit pin level
   output logic            tx_pin_oe,    // Transmit pin drive enable
   output logic            irq_req       // Buffer empty request
);

   // Software-visible control
   logic [7:0]    tx_ctrl_q;
   logic [7:0]    rx_ctrl_q;
   logic [7:0]    baud_ctrl_q;
   logic [15:0]   divisor_q;
   logic          irq_en_q;
   logic [7:0]    buffer_q;
   logic          buffer_ninth_q;
   logic          buffer_full_q;
   logic          write_seen_q;
   // Serializer
   ast_state_type state_q;
   logic [8:0]    shift_q;
   logic [3:0]    bit_cnt_q;
   logic [15:0]   baud_cnt_q;
   logic          line_q;
   logic          oe_q;

   logic          tx_enable;
   logic          port_enable;
   logic          sync_mode;
   logic          nine_bits;
   logic          running;
   logic          baud_tick;
   logic          load_now;
   logic          buf_write;
   logic          empty_flag;
   logic [15:0]   div_limit;
   logic          invert_line;

   // Physical level for a logical bit, inverted only in async mode
   function automatic logic ast_level(input logic bit_val,
                                      input logic invert);
      ast_level = bit_val ^ invert;
   endfunction : ast_level

   assign tx_enable   = tx_ctrl_q[`AST_TXC_ENABLE];
   assign port_enable = rx_ctrl_q[`AST_RXC_PORT_EN];
   assign sync_mode   = tx_ctrl_q[`AST_TXC_SYNC];
   assign nine_bits   = tx_ctrl_q[`AST_TXC_NINE_BITS];
   assign running     = tx_enable & port_enable & ~sync_mode;
   // Inversion the line logic applies this cycle; only async mode sees it
   assign invert_line = ~sync_mode & baud_ctrl_q[`AST_BDC_POLARITY];
   assign buf_write   = reg_write & (reg_addr == `AST_OFF_BUFFER);

   // Divider limit: only low byte counts in 8-bit mode
   assign div_limit = baud_ctrl_q[`AST_BDC_WIDE_DIV] ? divisor_q
                                : {8'h00, divisor_q[7:0]};

   // Register writes; the divisor is shared with the receiver side
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_ctrl_q   <= `AST_RST_TX_CTRL;
         rx_ctrl_q   <= `AST_RST_BYTE;
         baud_ctrl_q <= `AST_RST_BYTE;
         divisor_q   <= `AST_RST_DIVIDER;
         irq_en_q    <= 1'b0;
      end else if (reg_write) begin
         unique case (reg_addr)
            `AST_OFF_TX_CTRL:   tx_ctrl_q   <= reg_wdata;
            `AST_OFF_RX_CTRL:   rx_ctrl_q   <= reg_wdata;
            `AST_OFF_BAUD_CTRL: baud_ctrl_q <= reg_wdata;
            `AST_OFF_DIV_LOW:   divisor_q[7:0]  <= reg_wdata;
            `AST_OFF_DIV_HIGH:  divisor_q[15:8] <= reg_wdata;
            `AST_OFF_IRQ_EN:    irq_en_q <= reg_wdata[`AST_IEN_BUF_EMPTY];
            default: ;
         endcase
      end
   end

   // Baud tick: one cycle every div_limit+1 cycles while a frame runs
   always_ff @(posedge clock) begin
      if (rst || state_q == AST_IDLE || load_now) begin
         baud_cnt_q <= 16'h0000;
      end else if (baud_cnt_q >= div_limit) begin
         baud_cnt_q <= 16'h0000;
      end else begin
         baud_cnt_q <= baud_cnt_q + 16'h0001;
      end
   end
   assign baud_tick = (state_q != AST_IDLE) && (baud_cnt_q >= div_limit);

   // Shifter takes the buffer when idle or as the stop bit ends
   assign load_now = running && buffer_full_q &&
                     (state_q == AST_IDLE ||
                      (state_q == AST_STOP && baud_tick));

   // Transmit buffer: written by software, drained into the shifter.
   // A write while full overwrites the queued character.
   always_ff @(posedge clock) begin
      if (rst || !running) begin
         buffer_full_q <= 1'b0;
      end else if (buf_write) begin
         buffer_full_q <= 1'b1;
      end else if (load_now) begin
         buffer_full_q <= 1'b0;
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         buffer_q       <= `AST_RST_BYTE;
         buffer_ninth_q <= 1'b0;
      end else if (buf_write) begin
         buffer_q       <= reg_wdata;
         buffer_ninth_q <= tx_ctrl_q[`AST_TXC_NINTH_DATA];
      end
   end

   // Hides a fresh write for one cycle so the flag is read settled
   always_ff @(posedge clock) begin
      if (rst) begin
         write_seen_q <= 1'b0;
      end else begin
         write_seen_q <= buf_write;
      end
   end

   // Sequencer and hidden shift register
   always_ff @(posedge clock) begin
      if (rst || !running) begin
         state_q   <= AST_IDLE;
         shift_q   <= 9'h000;
         bit_cnt_q <= 4'h0;
      end else if (load_now) begin
         state_q   <= AST_START;
         shift_q   <= {buffer_ninth_q, buffer_q};
         bit_cnt_q <= 4'h0;
      end else if (baud_tick) begin
         unique case (state_q)
            AST_START: state_q <= AST_DATA;
            AST_DATA: begin
               shift_q   <= {1'b0, shift_q[8:1]};
               bit_cnt_q <= bit_cnt_q + 4'h1;
               if (bit_cnt_q == (nine_bits ? 4'h8 : 4'h7)) begin
                  state_q <= AST_STOP;
               end
            end
            AST_STOP:  state_q <= AST_IDLE;
            default:   state_q <= AST_IDLE;
         endcase
      end
   end

   // Line level registered; inversion ignored in sync mode
   always_ff @(posedge clock) begin
      if (rst) begin
         line_q <= 1'b1;
      end else begin
         unique case (state_q)
            AST_START: line_q <= ast_level(1'b0, ~sync_mode &
                                 baud_ctrl_q[`AST_BDC_POLARITY]);
            AST_DATA:  line_q <= ast_level(shift_q[0], ~sync_mode &
                                 baud_ctrl_q[`AST_BDC_POLARITY]);
            default:   line_q <= ast_level(1'b1, ~sync_mode &
                                 baud_ctrl_q[`AST_BDC_POLARITY]);
         endcase
      end
   end

   // Pin becomes an output one cycle after the port is enabled
   always_ff @(posedge clock) begin
      if (rst) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= port_enable;
      end
   end

   assign tx_pin_out = line_q;
   assign tx_pin_oe  = oe_q;

   // Flag is pure hardware state; no register write reaches it
   assign empty_flag = tx_enable & ~(buffer_full_q & ~write_seen_q);
   assign irq_req    = empty_flag & irq_en_q;

   // Read data, valid the cycle after the strobe
   always_ff @(posedge clock) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         unique case (reg_addr)
            `AST_OFF_BUFFER:    reg_rdata <= buffer_q;
            `AST_OFF_TX_CTRL:   reg_rdata <= {tx_ctrl_q[7:2],
                                 (state_q == AST_IDLE), tx_ctrl_q[0]};
            `AST_OFF_RX_CTRL:   reg_rdata <= rx_ctrl_q;
            `AST_OFF_BAUD_CTRL: reg_rdata <= baud_ctrl_q;
            `AST_OFF_DIV_LOW:   reg_rdata <= divisor_q[7:0];
            `AST_OFF_DIV_HIGH:  reg_rdata <= divisor_q[15:8];
            `AST_OFF_FLAGS:     reg_rdata <= {7'h00, empty_flag};
            `AST_OFF_IRQ_EN:    reg_rdata <= {7'h00, irq_en_q};
            default:            reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Idle line is mark whenever nothing is queued or shifting
   a_idle_mark: assert property (@(posedge clock) disable iff (rst)
      $past(state_q == AST_IDLE) && $past(state_q) == state_q |->
      tx_pin_out == (1'b1 ^ $past(invert_line)))
      else $error("idle line not at mark");
   a_start_space: assert property (@(posedge clock) disable iff (rst)
      state_q == AST_START && $past(state_q == AST_START) |=>
      tx_pin_out == (~sync_mode & baud_ctrl_q[`AST_BDC_POLARITY]))
      else $error("start bit not space");
   a_load_idle: assert property (@(posedge clock) disable iff (rst)
      buf_write && running && state_q == AST_IDLE && !buffer_full_q |=>
      ##1 state_q == AST_START)
      else $error("idle shifter did not load");
   a_stop_reload: assert property (@(posedge clock) disable iff (rst)
      running && buffer_full_q && state_q == AST_STOP && baud_tick &&
      !buf_write |=>
      state_q == AST_START && !buffer_full_q)
      else $error("queued character not taken after stop");
   a_flag_delay: assert property (@(posedge clock) disable iff (rst)
      buf_write && tx_enable |=> empty_flag)
      else $error("flag cleared in cycle after write");
   a_flag_enable: assert property (@(posedge clock) disable iff (rst)
      !tx_enable |-> !empty_flag && !irq_req)
      else $error("flag set while disabled");
   a_irq_gate: assert property (@(posedge clock) disable iff (rst)
      irq_req |-> empty_flag && irq_en_q)
      else $error("request without flag and enable");
   a_abandon: assert property (@(posedge clock) disable iff (rst)
      !running |=> state_q == AST_IDLE && !buffer_full_q)
      else $error("frame kept after disable");
   a_bit_count: assert property (@(posedge clock) disable iff (rst)
      state_q == AST_DATA && baud_tick && bit_cnt_q == 4'h7 && !nine_bits
      |=> state_q == AST_STOP || state_q == AST_IDLE)
      else $error("eight-bit frame length wrong");
   a_oe_port: assert property (@(posedge clock) disable iff (rst)
      port_enable |=> tx_pin_oe)
      else $error("pin not output with port enabled");

   // The line is registered, so every level check below looks one cycle
   // after the state that chose it and compares against that cycle's
   // inversion setting. Changing polarity or divisor mid-frame is legal
   // but leaves the frame in flight undefined for the far receiver; the
   // checks only follow what the logic does, never what the receiver
   // would make of it.

   // Line levels per state
   a_data_level: assert property (@(posedge clock) disable iff (rst)
      state_q == AST_DATA |=>
      tx_pin_out == ($past(shift_q[0]) ^ $past(invert_line)))
      else $error("data bit level wrong");

   a_stop_mark: assert property (@(posedge clock) disable iff (rst)
      state_q == AST_STOP |=>
      tx_pin_out == (1'b1 ^ $past(invert_line)))
      else $error("stop bit not mark");

   a_sync_line: assert property (@(posedge clock) disable iff (rst)
      sync_mode && $past(sync_mode) && $past(state_q == AST_IDLE) |->
      tx_pin_out == 1'b1)
      else $error("polarity applied in sync mode");

   a_sync_idle: assert property (@(posedge clock) disable iff (rst)
      sync_mode |=> state_q == AST_IDLE)
      else $error("serializer ran in sync mode");

   // Bit timing
   a_baud_wrap: assert property (@(posedge clock) disable iff (rst)
      baud_tick && !load_now |=> baud_cnt_q == 16'h0000)
      else $error("baud counter did not wrap");

   a_start_hold: assert property (@(posedge clock) disable iff (rst)
      state_q == AST_START && running && !baud_tick |=>
      state_q == AST_START)
      else $error("start bit cut short");

   a_narrow_div: assert property (@(posedge clock) disable iff (rst)
      !baud_ctrl_q[`AST_BDC_WIDE_DIV] |-> div_limit[15:8] == 8'h00)
      else $error("high divisor byte used in 8-bit mode");

   // Frame shape and shifting
   a_nine_count: assert property (@(posedge clock) disable iff (rst)
      state_q == AST_DATA && baud_tick && running && nine_bits &&
      bit_cnt_q == 4'h8 |=> state_q == AST_STOP)
      else $error("nine-bit frame length wrong");

   a_stop_idle: assert property (@(posedge clock) disable iff (rst)
      state_q == AST_STOP && baud_tick && running && !load_now |=>
      state_q == AST_IDLE)
      else $error("more than one stop bit with nothing queued");

   a_shift_lsb: assert property (@(posedge clock) disable iff (rst)
      state_q == AST_DATA && baud_tick && running |=>
      shift_q == {1'b0, $past(shift_q[8:1])})
      else $error("shifter not moving toward bit zero");

   a_load_source: assert property (@(posedge clock) disable iff (rst)
      load_now |=> shift_q == $past({buffer_ninth_q, buffer_q}))
      else $error("shifter loaded from elsewhere than buffer");

   a_ninth_take: assert property (@(posedge clock) disable iff (rst)
      buf_write |=>
      buffer_ninth_q == $past(tx_ctrl_q[`AST_TXC_NINTH_DATA]))
      else $error("ninth bit not taken at buffer write");

   // Queue and flag
   a_queue_hold: assert property (@(posedge clock) disable iff (rst)
      buffer_full_q && running && state_q == AST_DATA |=> buffer_full_q)
      else $error("queued character dropped mid-frame");

   a_flag_rise: assert property (@(posedge clock) disable iff (rst)
      $rose(tx_enable) |-> empty_flag)
      else $error("flag not set on transmit enable");

   a_flag_empty: assert property (@(posedge clock) disable iff (rst)
      tx_enable && !buffer_full_q |-> empty_flag)
      else $error("flag clear with empty buffer");

   a_irq_off: assert property (@(posedge clock) disable iff (rst)
      !irq_en_q |-> !irq_req)
      else $error("request while masked");

   a_oe_off: assert property (@(posedge clock) disable iff (rst)
      !port_enable |=> !tx_pin_oe)
      else $error("pin driven with port disabled");

endmodule : ast_transmitter
`default_nettype wire

// *** verif/ast_rx_model.sv ***
/*
 Behavioural receiver on the far side of the serial line.
 Assumes the bench supplies the bit period in clock cycles.
*/
`timescale 1ns/100ps
`default_nettype none

module ast_rx_model (
   input  wire logic       clock,    // Bench clock
   input  wire logic       line,     // Serial line level
   input  wire logic       invert,   // Line is low-true
   input  wire logic       nine,     // Nine data bits per frame
   input  var  int         period,   // Bit period in clocks
   output logic      [8:0] rx_data,  // Last character received
   output var  int         rx_count, // Frames received
   output var  int         stamp,    // Cycle of last start detection
   output logic            rx_ferr   // Start or stop level wrong
);
   int         cyc = 0;
   logic [8:0] shift;

   // Free-running cycle count for start stamps
   always @(posedge clock) cyc <= cyc + 1;

   // Mid-bit sampling; no parity is checked, the ninth bit is plain data
   initial begin
      rx_data = 9'h000;
      rx_count = 0;
      stamp = 0;
      rx_ferr = 1'b0;
      forever begin
         @(posedge clock);
         if ((line ^ invert) === 1'b0) begin
            stamp = cyc;
            shift = 9'h000;
            repeat (period / 2) @(posedge clock);
            if ((line ^ invert) !== 1'b0) rx_ferr = 1'b1;
            for (int i = 0; i < (nine ? 9 : 8); i++) begin
               repeat (period) @(posedge clock);
               shift[i] = line ^ invert;
            end
            repeat (period) @(posedge clock);
            if ((line ^ invert) !== 1'b1) rx_ferr = 1'b1;
            rx_data = shift;
            rx_count = rx_count + 1;
         end
      end
   end
endmodule : ast_rx_model
`default_nettype wire

// *** verif/testbench.sv ***
/*
 Self-checking bench for the serial transmitter: register tasks drive
 the plain register port, a receiver model decodes the line.
 Assumes the receiver model is compiled before this file.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ast_params.svh"

module testbench;
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_write = 1'b0;
   logic       reg_read = 1'b0;
   logic [7:0] reg_rdata;
   logic       tx_pin_out;
   logic       tx_pin_oe;
   logic       irq_req;
   logic       inv = 1'b0;
   logic       nine = 1'b0;
   logic [8:0] rx_data;
   logic       rx_ferr;
   logic [7:0] rd;
   int         per = 4;
   int         fails = 0;
   int         checks_done = 0;
   int         count;
   int         stamp;
   wire        line = tx_pin_oe ? tx_pin_out : 1'b1; // Pulled up if undriven

   // 100 MHz clock
   always #5 clock = ~clock;

   ast_transmitter ast_transmitter_inst (.clock(clock), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_pin_out(tx_pin_out),
      .tx_pin_oe(tx_pin_oe), .irq_req(irq_req));

   ast_rx_model ast_rx_model_inst (.clock(clock), .line(line),
      .invert(inv), .nine(nine), .period(per), .rx_data(rx_data),
      .rx_count(count), .stamp(stamp), .rx_ferr(rx_ferr));

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out

   task automatic check(input string name, input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 rd = reg_rdata;
      check(n, {8'h00, rd}, {8'h00, e});
   endtask : rchk

   // Bounded wait; a hang counts as a mismatch
   task automatic wait_rx(input int n);
      int k;
      k = 0;
      while (count < n && k < 30000) begin
         @(posedge clock);
         k++;
      end
      if (k >= 30000) begin
         fails++;
         close_out();
      end
   endtask : wait_rx

   // Two characters back to back: the second waits in the buffer
   task automatic pair(input logic [8:0] a, input logic [8:0] b);
      int c0;
      int t0;
      c0 = count;
      wr(`AST_OFF_BUFFER, a[7:0]);
      wr(`AST_OFF_BUFFER, b[7:0]);
      rchk("flag busy", `AST_OFF_FLAGS, 8'h00);
      wait_rx(c0 + 1);
      t0 = stamp;
      check("first char", {7'h00, rx_data}, {7'h00, a});
      wait_rx(c0 + 2);
      check("second char", {7'h00, rx_data}, {7'h00, b});
      check("frame span", 16'(stamp - t0),
            16'((nine ? 11 : 10) * per));
      check("framing", {15'h0000, rx_ferr}, 16'h0000);
      repeat (per) @(posedge clock);
      rchk("flag free", `AST_OFF_FLAGS, 8'h01);
   endtask : pair

   // Watchdog well beyond the planned run
   initial begin
      repeat (60000) @(posedge clock);
      fails++;
      close_out();
   end

   initial begin
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      rchk("tx ctrl", `AST_OFF_TX_CTRL, `AST_RST_TX_CTRL);
      rchk("flag off", `AST_OFF_FLAGS, 8'h00);
      rchk("unmapped", 4'h9, 8'h00);
      check("idle level", {15'h0000, tx_pin_out}, 16'h0001);
      check("pin off", {15'h0000, tx_pin_oe}, 16'h0000);
      wr(`AST_OFF_DIV_LOW, 8'h03);
      wr(`AST_OFF_RX_CTRL, 8'h80);
      wr(`AST_OFF_TX_CTRL, 8'h20);
      check("pin on", {15'h0000, tx_pin_oe}, 16'h0001);
      rchk("flag on", `AST_OFF_FLAGS, 8'h01);
      wr(`AST_OFF_FLAGS, 8'h00);
      rchk("flag ro", `AST_OFF_FLAGS, 8'h01);
      wr(`AST_OFF_IRQ_EN, 8'h01);
      #1 check("irq on", {15'h0000, irq_req}, 16'h0001);
      wr(`AST_OFF_IRQ_EN, 8'h00);
      #1 check("irq off", {15'h0000, irq_req}, 16'h0000);
      rchk("flag kept", `AST_OFF_FLAGS, 8'h01);
      $display("test setup done");
      pair(8'h55, 8'h3C);
      rchk("shifter idle", `AST_OFF_TX_CTRL, 8'h22);
      $display("test back to back done");
      nine = 1'b1;
      wr(`AST_OFF_TX_CTRL, 8'h61);
      pair(9'h10F, 9'h1F0);
      wr(`AST_OFF_TX_CTRL, 8'h60);
      pair(8'h80, 8'h01);
      check("ninth bit", {7'h00, rx_data}, 16'h0001);
      nine = 1'b0;
      wr(`AST_OFF_TX_CTRL, 8'h20);
      $display("test nine bits done");
      wr(`AST_OFF_BAUD_CTRL, 8'h10);
      @(posedge clock);
      #1 inv = 1'b1;
      check("inverted idle", {15'h0000, tx_pin_out}, 16'h0000);
      pair(8'h96, 8'h69);
      wr(`AST_OFF_BAUD_CTRL, 8'h00);
      @(posedge clock);
      #1 inv = 1'b0;
      check("true idle", {15'h0000, tx_pin_out}, 16'h0001);
      $display("test polarity done");
      wr(`AST_OFF_DIV_HIGH, 8'h01);
      wr(`AST_OFF_BAUD_CTRL, 8'h08);
      per = 260;
      pair(8'hA5, 8'h5A);
      wr(`AST_OFF_BAUD_CTRL, 8'h00);
      per = 4;
      pair(8'hC3, 8'h3C);
      $display("test divider done");
      wr(`AST_OFF_BUFFER, 8'h00);
      repeat (6) @(posedge clock);
      wr(`AST_OFF_TX_CTRL, 8'h00);
      repeat (2) @(posedge clock);
      #1 check("abort idle", {15'h0000, tx_pin_out}, 16'h0001);
      rchk("abort flag", `AST_OFF_FLAGS, 8'h00);
      rchk("abort ctrl", `AST_OFF_TX_CTRL, 8'h02);
      $display("test abort done");
      close_out();
   end
endmodule : testbench
`default_nettype wire
